/* File: bench/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
    import vmet_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_r = 1'b0;
    logic wr_r = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic wq, go = 1'b0, g_tag = 1'b0, f_valid, f_tag, d_valid, d_drop, nv_save;
    logic [4:0] g_port = 5'h00;
    logic [4:0] f_port;
    logic [11:0] g_vid = 12'h000;
    logic [11:0] f_vid, d_vid;
    logic [17:0] d_map, d_ins, d_str;
    int n_errors = 0;
    int checks_done = 0;
    int n_save = 0;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) if (nv_save === 1'b1) n_save <= n_save + 1;
    vmet_core u_dut (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(adr),
        .avs_read_in(rd_r), .avs_write_in(wr_r), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
        .frm_valid_in(f_valid), .frm_port_in(f_port), .frm_tagged_in(f_tag),
        .frm_vid_in(f_vid), .dec_valid_out(d_valid), .dec_drop_out(d_drop),
        .dec_vid_out(d_vid), .dec_port_map_out(d_map), .dec_insert_map_out(d_ins),
        .dec_strip_map_out(d_str), .nv_save_out(nv_save));
    vmet_station_model u_stn (.clk_in(clk_in), .send_in(go), .port_in(g_port),
        .tagged_in(g_tag), .vid_in(g_vid), .frm_valid_out(f_valid),
        .frm_port_out(f_port), .frm_tagged_out(f_tag), .frm_vid_out(f_vid));
    // ==========
    // Shared drivers
    task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_in);
        adr <= a;
        rd_r <= rw;
        wr_r <= !rw;
        wd <= d;
        do @(posedge clk_in); while (wq !== 1'b0);
        q = rdat;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b1, a, 32'h0000_0000, q);
        `CHK("readdata", e, q)
    endtask
    task automatic frame(input logic [4:0] p, input logic t, input logic [11:0] v,
        input logic dr, input logic [11:0] ev, input logic [17:0] m, input logic [17:0] i,
        input logic [17:0] s);
        @(posedge clk_in);
        go <= 1'b1;
        g_port <= p;
        g_tag <= t;
        g_vid <= v;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK("dec_valid", 1'b1, d_valid)
        `CHK("dec_drop", dr, d_drop)
        if (!dr) `CHK("dec_vid", ev, d_vid)
        `CHK("port_map", m, d_map)
        `CHK("insert_map", i, d_ins)
        `CHK("strip_map", s, d_str)
    endtask
    task automatic set_vlan(input logic [11:0] v, input logic [17:0] e, input logic [17:0] f,
        input logic [17:0] t);
        wr(VMET_OFS_VID, {20'h0_0000, v});
        wr(VMET_OFS_NAME, 32'h0000_0041);
        wr(VMET_OFS_EGRESS, {14'h0000, e});
        wr(VMET_OFS_FORBID, {14'h0000, f});
        wr(VMET_OFS_TAG, {14'h0000, t});
        wr(VMET_OFS_CTRL, 32'h0000_0001);
    endtask
    // ==========
    // Scenarios
    task automatic t_factory();
        frame(5'd2, 1'b0, 12'h000, 1'b0, 12'h001, 18'h3FFFB, 18'h0, 18'h0);
        frame(5'd3, 1'b1, 12'h001, 1'b0, 12'h001, 18'h3FFF7, 18'h0, 18'h3FFF7);
    endtask
    task automatic t_add();
        set_vlan(12'h005, 18'h00053, 18'h00040, 18'h00002);
        frame(5'd0, 1'b1, 12'h005, 1'b0, 12'h005, 18'h12, 18'h0, 18'h10);
        frame(5'd2, 1'b0, 12'h000, 1'b0, 12'h001, 18'h3FFE8, 18'h0, 18'h0);
        wr(VMET_OFS_CTRL, 32'h0000_0010);
        rdc(VMET_OFS_STATUS, 32'h0000_0004);
        rdc(VMET_OFS_EGRESS, 32'h0000_0013);
        `CHK("save_pulses", 0, n_save)
    endtask
    task automatic t_dyn();
        wr(VMET_OFS_DYN_JOIN, 32'h0006_0005);
        rdc(VMET_OFS_STATUS, 32'h0000_0005);
        wr(VMET_OFS_STATUS, 32'h0000_0001);
        wr(VMET_OFS_DYN_JOIN, 32'h0007_0005);
        rdc(VMET_OFS_STATUS, 32'h0000_0004);
        frame(5'd0, 1'b1, 12'h005, 1'b0, 12'h005, 18'h92, 18'h0, 18'h90);
    endtask
    task automatic t_native();
        wr(VMET_OFS_PORT_SEL, 32'h0000_0000);
        wr(VMET_OFS_PORT_CFG, 32'h0000_0005);
        frame(5'd0, 1'b0, 12'h000, 1'b0, 12'h005, 18'h92, 18'h02, 18'h0);
        wr(VMET_OFS_PORT_CFG, 32'h0001_0005);
        frame(5'd0, 1'b1, 12'h001, 1'b1, 12'h000, 18'h0, 18'h0, 18'h0);
    endtask
    task automatic t_reconf();
        set_vlan(12'h001, 18'h3FFFF, 18'h00008, 18'h00000);
        frame(5'd2, 1'b0, 12'h000, 1'b0, 12'h001, 18'h3FFF3, 18'h0, 18'h0);
        wr(VMET_OFS_CTRL, 32'h0000_0003);
        rdc(VMET_OFS_STATUS, 32'h0000_0006);
        wr(VMET_OFS_VID, 32'h0000_0005);
        wr(VMET_OFS_CTRL, 32'h0000_0003);
        wr(VMET_OFS_STATUS, 32'h0000_0003);
        wr(VMET_OFS_CTRL, 32'h0000_0010);
        rdc(VMET_OFS_STATUS, 32'h0000_0000);
        rdc(8'h3C, 32'h0000_0000);
        wr(VMET_OFS_CTRL, 32'h0000_0004);
        repeat (3) @(posedge clk_in);
        `CHK("save_pulses", 1, n_save)
        wr(VMET_OFS_CTRL, 32'h0000_0008);
        frame(5'd0, 1'b0, 12'h000, 1'b0, 12'h001, 18'h3FFFE, 18'h0, 18'h0);
    endtask
    task automatic close_out();
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        t_factory();
        t_add();
        t_dyn();
        t_native();
        t_reconf();
        close_out();
    end
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule

/* File: bench/vmet_core_checker_properties.sv */
`timescale 1ns/1ps
module vmet_core_checker #(
    parameter int NUM_PORTS = 18,
    parameter int VID_W = 12
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [vmet_pkg::VMET_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [vmet_pkg::VMET_DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [vmet_pkg::VMET_DATA_W-1:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic frm_valid_in,
    input wire logic [vmet_pkg::VMET_PORT_W-1:0] frm_port_in,
    input wire logic frm_tagged_in,
    input wire logic [VID_W-1:0] frm_vid_in,
    input wire logic dec_valid_out,
    input wire logic dec_drop_out,
    input wire logic [VID_W-1:0] dec_vid_out,
    input wire logic [NUM_PORTS-1:0] dec_port_map_out,
    input wire logic [NUM_PORTS-1:0] dec_insert_map_out,
    input wire logic [NUM_PORTS-1:0] dec_strip_map_out,
    input wire logic nv_save_out
);
    import vmet_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic req;
    assign req = avs_read_in | avs_write_in;
    // ==========
    // Register bus
    a_wait_one_state: assert property (req && !$past(req) |=> !avs_waitrequest_out)
        else $error("waitrequest not low one cycle after request");
    a_wait_low_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait_high: assert property (!req |-> avs_waitrequest_out)
        else $error("waitrequest low with no request");
    a_save_one_pulse: assert property (nv_save_out |=> !nv_save_out)
        else $error("save request longer than one cycle");
    // ==========
    // Frame decision
    a_dec_one_later: assert property (1'b1 |=> dec_valid_out == $past(frm_valid_in))
        else $error("decision not one cycle after descriptor");
    a_drop_no_maps: assert property (dec_drop_out |-> dec_port_map_out == '0
        && dec_insert_map_out == '0 && dec_strip_map_out == '0)
        else $error("dropped frame still has egress ports");
    a_no_hairpin: assert property (dec_valid_out && !dec_drop_out
        |-> !dec_port_map_out[$past(frm_port_in)])
        else $error("frame sent back to its ingress port");
    a_edit_in_map: assert property (dec_valid_out
        |-> ((dec_insert_map_out | dec_strip_map_out) & ~dec_port_map_out) == '0)
        else $error("tag edit on a port outside the egress map");
    a_tagged_no_insert: assert property (dec_valid_out && $past(frm_tagged_in)
        |-> dec_insert_map_out == '0)
        else $error("second tag inserted on tagged frame");
    a_plain_no_strip: assert property (dec_valid_out && !$past(frm_tagged_in)
        |-> dec_strip_map_out == '0)
        else $error("strip requested on untagged frame");
    a_tag_vid_kept: assert property (dec_valid_out && !dec_drop_out && $past(frm_tagged_in)
        |-> dec_vid_out == $past(frm_vid_in))
        else $error("tagged frame moved to another group");
    c_drop: cover property (dec_drop_out);
    c_insert: cover property (dec_valid_out && dec_insert_map_out != '0);
    c_save: cover property (nv_save_out);
endmodule
bind vmet_core vmet_core_checker #(.NUM_PORTS(NUM_PORTS), .VID_W(VID_W)) u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .frm_valid_in(frm_valid_in), .frm_port_in(frm_port_in), .frm_tagged_in(frm_tagged_in),
    .frm_vid_in(frm_vid_in), .dec_valid_out(dec_valid_out), .dec_drop_out(dec_drop_out),
    .dec_vid_out(dec_vid_out), .dec_port_map_out(dec_port_map_out),
    .dec_insert_map_out(dec_insert_map_out), .dec_strip_map_out(dec_strip_map_out),
    .nv_save_out(nv_save_out));

/* File: bench/vmet_station_model.sv */
`timescale 1ns/1ps
module vmet_station_model (
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic [4:0] port_in,
    input wire logic tagged_in,
    input wire logic [11:0] vid_in,
    output logic frm_valid_out,
    output logic [4:0] frm_port_out,
    output logic frm_tagged_out,
    output logic [11:0] frm_vid_out
);
    // ==========
    // One descriptor per send; lines scramble between frames so stale values never match
    initial begin
        frm_valid_out = 1'b0;
        frm_port_out = 5'h00;
        frm_tagged_out = 1'b0;
        frm_vid_out = 12'h000;
    end
    always @(posedge clk_in) begin
        frm_valid_out <= send_in;
        frm_port_out <= send_in ? port_in : ~frm_port_out;
        frm_tagged_out <= send_in ? tagged_in : ~frm_tagged_out;
        frm_vid_out <= (send_in && tagged_in) ? vid_in : ~frm_vid_out;
    end
endmodule

/* File: design/vmet_core.sv */
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - VID 1 reserved as fallback group
// - Factory init puts every port in fallback
// - New VLAN members leave fallback group (on apply only; a dynamic join leaves the port in fallback)
// - Reconfiguring fallback re-adds all, then trims
// - Never forward between different VLANs
// - Static egress members transmit VLAN traffic
// - Forbidden ports excluded, dynamic join refused
// - Non-member excluded but may join dynamically
// - Untagged port strips tags, passes untagged
// - Tagged port inserts tag on untagged frames
// - Tagged port passes tagged frames unchanged
// - Add, modify, delete entries by VID, name
// - Apply is immediate; save separate command
// - Untagged ingress uses port native group
// - Ingress filter drops non-member tagged frames, except those tagged with the port native VID
module vmet_core #(
    parameter int NUM_PORTS = vmet_pkg::VMET_NUM_PORTS,
    parameter int VID_W = vmet_pkg::VMET_VID_W
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [vmet_pkg::VMET_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [vmet_pkg::VMET_DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [vmet_pkg::VMET_DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic frm_valid_in,
    input wire logic [vmet_pkg::VMET_PORT_W-1:0] frm_port_in,
    input wire logic frm_tagged_in,
    input wire logic [VID_W-1:0] frm_vid_in,
    output logic dec_valid_out,
    output logic dec_drop_out,
    output logic [VID_W-1:0] dec_vid_out,
    output logic [NUM_PORTS-1:0] dec_port_map_out,
    output logic [NUM_PORTS-1:0] dec_insert_map_out,
    output logic [NUM_PORTS-1:0] dec_strip_map_out,
    output logic nv_save_out
);
    import vmet_pkg::*;

    localparam int DEPTH = 1 << VID_W;
    localparam logic [NUM_PORTS-1:0] ALL_PORTS = {NUM_PORTS{1'b1}};
    localparam logic [VID_W-1:0] FB_VID = VMET_FALLBACK_VID[VID_W-1:0];
    localparam logic [VID_W-1:0] NO_VID = VMET_NULL_VID[VID_W-1:0];

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Membership store
    // ==========================================================
    // Member code per port is kept as two bit maps: egress and forbid.
    logic [NUM_PORTS-1:0] tbl_egress [0:DEPTH-1];
    logic [NUM_PORTS-1:0] tbl_forbid [0:DEPTH-1];
    logic [NUM_PORTS-1:0] tbl_tag [0:DEPTH-1];
    logic [31:0] tbl_name [0:DEPTH-1];
    logic [DEPTH-1:0] tbl_valid_reg;
    logic [NUM_PORTS-1:0] fb_egress_reg;
    logic [NUM_PORTS-1:0] fb_forbid_reg;
    logic [NUM_PORTS-1:0] fb_tag_reg;
    logic [31:0] fb_name_reg;

    // ==========================================================
    // Bus slave and staging registers
    // ==========================================================
    logic waitreq_reg;
    logic [31:0] rdata_reg;
    logic [VID_W-1:0] stg_vid_reg;
    logic [NUM_PORTS-1:0] stg_egress_reg;
    logic [NUM_PORTS-1:0] stg_forbid_reg;
    logic [NUM_PORTS-1:0] stg_tag_reg;
    logic [31:0] stg_name_reg;
    logic [VMET_PORT_W-1:0] port_sel_reg;
    logic refused_reg;
    logic bad_op_reg;
    logic save_reg;
    logic [VID_W-1:0] native_id_reg [0:NUM_PORTS-1];
    logic [NUM_PORTS-1:0] filter_en_reg;

    logic wr_fire;
    logic rd_take;
    logic [31:0] wr_word;
    logic ctrl_wr;
    logic do_apply;
    logic do_delete;
    logic do_fetch;
    logic do_factory;
    logic stg_is_fb;
    logic stg_is_null;
    logic add_ok;
    logic del_ok;
    logic dyn_wr;
    logic [VID_W-1:0] dyn_vid;
    logic [VMET_PORT_W-1:0] dyn_port;
    logic dyn_hit;
    logic dyn_forbid;
    logic dyn_ok;
    logic dyn_refuse;

    // One wait state: request is seen with waitrequest high, answered next edge
    assign wr_fire = avs_write_in && !waitreq_reg;
    assign rd_take = avs_read_in && waitreq_reg;
    assign wr_word = be_merge(VMET_RST_WORD, avs_writedata_in, avs_byteenable_in);
    assign ctrl_wr = wr_fire && (avs_address_in == VMET_OFS_CTRL) && avs_byteenable_in[0];
    assign do_factory = ctrl_wr && avs_writedata_in[VMET_CTRL_FACTORY];
    assign do_apply = ctrl_wr && avs_writedata_in[VMET_CTRL_APPLY] && !do_factory;
    assign do_delete = do_apply && avs_writedata_in[VMET_CTRL_DELETE];
    assign do_fetch = ctrl_wr && avs_writedata_in[VMET_CTRL_FETCH] && !do_factory;
    assign stg_is_fb = (stg_vid_reg == FB_VID);
    assign stg_is_null = (stg_vid_reg == NO_VID);
    // The fallback group cannot be deleted or reused; VID 0 names no group
    assign add_ok = do_apply && !do_delete && !stg_is_null;
    assign del_ok = do_delete && !stg_is_fb && !stg_is_null;

    assign dyn_wr = wr_fire && (avs_address_in == VMET_OFS_DYN_JOIN);
    assign dyn_vid = avs_writedata_in[VID_W-1:0];
    assign dyn_port = avs_writedata_in[VMET_DYN_PORT_LSB +: VMET_PORT_W];
    assign dyn_hit = (dyn_vid == FB_VID) || tbl_valid_reg[dyn_vid];
    assign dyn_forbid = (dyn_vid == FB_VID) ? fb_forbid_reg[dyn_port] : tbl_forbid[dyn_vid][dyn_port];
    assign dyn_ok = dyn_wr && dyn_hit && (int'(dyn_port) < NUM_PORTS) && !dyn_forbid;
    assign dyn_refuse = dyn_wr && dyn_hit && (int'(dyn_port) < NUM_PORTS) && dyn_forbid;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            waitreq_reg <= 1'b1;
        end else if ((avs_read_in || avs_write_in) && waitreq_reg) begin
            waitreq_reg <= 1'b0;
        end else begin
            waitreq_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            stg_vid_reg <= NO_VID;
            stg_egress_reg <= '0;
            stg_forbid_reg <= '0;
            stg_tag_reg <= '0;
            stg_name_reg <= VMET_RST_WORD;
            port_sel_reg <= '0;
        end else if (do_fetch) begin
            stg_egress_reg <= stg_is_fb ? fb_egress_reg : tbl_egress[stg_vid_reg];
            stg_forbid_reg <= stg_is_fb ? fb_forbid_reg : tbl_forbid[stg_vid_reg];
            stg_tag_reg <= stg_is_fb ? fb_tag_reg : tbl_tag[stg_vid_reg];
            stg_name_reg <= stg_is_fb ? fb_name_reg : tbl_name[stg_vid_reg];
        end else if (wr_fire) begin
            unique case (avs_address_in)
                VMET_OFS_VID: stg_vid_reg <= VID_W'(be_merge(32'(stg_vid_reg), wr_word,
                                                             avs_byteenable_in));
                VMET_OFS_EGRESS: stg_egress_reg <= NUM_PORTS'(be_merge(32'(stg_egress_reg),
                                                             wr_word, avs_byteenable_in));
                VMET_OFS_FORBID: stg_forbid_reg <= NUM_PORTS'(be_merge(32'(stg_forbid_reg),
                                                             wr_word, avs_byteenable_in));
                VMET_OFS_TAG: stg_tag_reg <= NUM_PORTS'(be_merge(32'(stg_tag_reg), wr_word,
                                                             avs_byteenable_in));
                VMET_OFS_NAME: stg_name_reg <= be_merge(stg_name_reg, wr_word, avs_byteenable_in);
                VMET_OFS_PORT_SEL: begin
                    if (avs_byteenable_in[0]) begin
                        port_sel_reg <= avs_writedata_in[VMET_PORT_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Per-port ingress settings
    // ==========================================================
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                native_id_reg[p] <= FB_VID;
            end
            filter_en_reg <= '0;
        end else if (do_factory) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                native_id_reg[p] <= FB_VID;
            end
            filter_en_reg <= '0;
        end else if (wr_fire && (avs_address_in == VMET_OFS_PORT_CFG)
                     && (int'(port_sel_reg) < NUM_PORTS)) begin
            if (avs_byteenable_in[0] && avs_byteenable_in[1]) begin
                native_id_reg[port_sel_reg] <= avs_writedata_in[VID_W-1:0];
            end
            if (avs_byteenable_in[2]) begin
                filter_en_reg[port_sel_reg] <= avs_writedata_in[VMET_PCFG_FILTER];
            end
        end
    end

    // ==========================================================
    // Table update: apply, delete, dynamic join
    // ==========================================================
    // Entry storage has no reset; the valid map guards lookups, but a fetch copies the entry whatever its valid bit.
    always_ff @(posedge clk_in) begin
        if (add_ok && !stg_is_fb) begin
            tbl_egress[stg_vid_reg] <= stg_egress_reg & ~stg_forbid_reg;
            tbl_forbid[stg_vid_reg] <= stg_forbid_reg;
            tbl_tag[stg_vid_reg] <= stg_tag_reg;
            tbl_name[stg_vid_reg] <= stg_name_reg;
        end else if (dyn_ok && (dyn_vid != FB_VID)) begin
            tbl_egress[dyn_vid][dyn_port] <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tbl_valid_reg <= '0;
        end else if (do_factory) begin
            tbl_valid_reg <= '0;
        end else if (add_ok && !stg_is_fb) begin
            tbl_valid_reg[stg_vid_reg] <= 1'b1;
        end else if (del_ok) begin
            tbl_valid_reg[stg_vid_reg] <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            fb_egress_reg <= ALL_PORTS;
            fb_forbid_reg <= '0;
            fb_tag_reg <= '0;
            fb_name_reg <= VMET_RST_WORD;
        end else if (do_factory) begin
            fb_egress_reg <= ALL_PORTS;
            fb_forbid_reg <= '0;
            fb_tag_reg <= '0;
            fb_name_reg <= VMET_RST_WORD;
        end else if (add_ok && stg_is_fb) begin
            // All ports rejoin, then the unwanted ones are trimmed in the same step
            fb_egress_reg <= ALL_PORTS & stg_egress_reg & ~stg_forbid_reg;
            fb_forbid_reg <= stg_forbid_reg;
            fb_tag_reg <= stg_tag_reg;
            fb_name_reg <= stg_name_reg;
        end else if (add_ok) begin
            fb_egress_reg <= fb_egress_reg & ~(stg_egress_reg & ~stg_forbid_reg);
        end else if (dyn_ok && (dyn_vid == FB_VID)) begin
            fb_egress_reg[dyn_port] <= 1'b1;
        end
    end

    // ==========================================================
    // Status and save
    // ==========================================================
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            refused_reg <= 1'b0;
        end else if (dyn_refuse) begin
            refused_reg <= 1'b1;
        end else if (wr_fire && (avs_address_in == VMET_OFS_STATUS) && avs_byteenable_in[0]
                     && avs_writedata_in[VMET_ST_REFUSED]) begin
            refused_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bad_op_reg <= 1'b0;
        end else if (do_apply && !add_ok && !del_ok) begin
            bad_op_reg <= 1'b1;
        end else if (wr_fire && (avs_address_in == VMET_OFS_STATUS) && avs_byteenable_in[0]
                     && avs_writedata_in[VMET_ST_BAD_OP]) begin
            bad_op_reg <= 1'b0;
        end
    end

    // Saving is only a request to the storage agent; running state is already live
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            save_reg <= 1'b0;
        end else begin
            save_reg <= ctrl_wr && avs_writedata_in[VMET_CTRL_SAVE];
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_reg <= VMET_RST_WORD;
        end else if (rd_take) begin
            unique case (avs_address_in)
                VMET_OFS_VID: rdata_reg <= 32'(stg_vid_reg);
                VMET_OFS_EGRESS: rdata_reg <= 32'(stg_egress_reg);
                VMET_OFS_FORBID: rdata_reg <= 32'(stg_forbid_reg);
                VMET_OFS_TAG: rdata_reg <= 32'(stg_tag_reg);
                VMET_OFS_NAME: rdata_reg <= stg_name_reg;
                VMET_OFS_STATUS: rdata_reg <= 32'({stg_is_fb || tbl_valid_reg[stg_vid_reg],
                                                   bad_op_reg, refused_reg});
                VMET_OFS_PORT_SEL: rdata_reg <= 32'(port_sel_reg);
                VMET_OFS_PORT_CFG: rdata_reg <= (int'(port_sel_reg) < NUM_PORTS) ?
                    (32'(filter_en_reg[port_sel_reg]) << VMET_PCFG_FILTER)
                    | 32'(native_id_reg[port_sel_reg]) : VMET_RST_WORD;
                default: rdata_reg <= VMET_RST_WORD;
            endcase
        end
    end

    // ==========================================================
    // Frame decision
    // ==========================================================
    logic [VID_W-1:0] cls_vid;
    logic cls_known;
    logic [NUM_PORTS-1:0] cls_egress;
    logic [NUM_PORTS-1:0] cls_tag;
    logic [NUM_PORTS-1:0] src_bit;
    logic src_member;
    logic frm_drop;
    logic [NUM_PORTS-1:0] fwd_map;

    always_comb begin
        cls_vid = frm_tagged_in ? frm_vid_in : native_id_reg[frm_port_in];
        cls_known = (cls_vid == FB_VID) || tbl_valid_reg[cls_vid];
        cls_egress = '0;
        cls_tag = '0;
        if (cls_vid == FB_VID) begin
            cls_egress = fb_egress_reg;
            cls_tag = fb_tag_reg;
        end else if (cls_known) begin
            cls_egress = tbl_egress[cls_vid];
            cls_tag = tbl_tag[cls_vid];
        end
        src_bit = NUM_PORTS'(1) << frm_port_in;
        src_member = |(cls_egress & src_bit);
        frm_drop = (filter_en_reg[frm_port_in] && frm_tagged_in && !src_member
                    && (frm_vid_in != native_id_reg[frm_port_in]))
                   || (int'(frm_port_in) >= NUM_PORTS);
        // Only static or joined egress members of the frame's own VLAN receive it
        fwd_map = frm_drop ? '0 : (cls_egress & ~src_bit);
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dec_valid_out <= 1'b0;
            dec_drop_out <= 1'b0;
            dec_vid_out <= NO_VID;
            dec_port_map_out <= '0;
            dec_insert_map_out <= '0;
            dec_strip_map_out <= '0;
        end else begin
            dec_valid_out <= frm_valid_in;
            dec_drop_out <= frm_valid_in && frm_drop;
            dec_vid_out <= cls_vid;
            dec_port_map_out <= frm_valid_in ? fwd_map : '0;
            // Tagged-mode ports add a tag only to untagged frames
            dec_insert_map_out <= (frm_valid_in && !frm_tagged_in) ?
                                  (fwd_map & cls_tag) : '0;
            dec_strip_map_out <= (frm_valid_in && frm_tagged_in) ?
                                 (fwd_map & ~cls_tag) : '0;
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = waitreq_reg;
    assign nv_save_out = save_reg;

endmodule

/* File: design/vmet_pkg.sv */
package vmet_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int VMET_ADDR_W = 8;
    localparam int VMET_DATA_W = 32;
    localparam int VMET_VID_W = 12;
    localparam int VMET_NUM_PORTS = 18;
    localparam int VMET_PORT_W = 5;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] VMET_OFS_CTRL = 8'h00;
    localparam logic [7:0] VMET_OFS_VID = 8'h04;
    localparam logic [7:0] VMET_OFS_EGRESS = 8'h08;
    localparam logic [7:0] VMET_OFS_FORBID = 8'h0C;
    localparam logic [7:0] VMET_OFS_TAG = 8'h10;
    localparam logic [7:0] VMET_OFS_NAME = 8'h14;
    localparam logic [7:0] VMET_OFS_STATUS = 8'h18;
    localparam logic [7:0] VMET_OFS_PORT_SEL = 8'h1C;
    localparam logic [7:0] VMET_OFS_PORT_CFG = 8'h20;
    localparam logic [7:0] VMET_OFS_DYN_JOIN = 8'h24;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int VMET_CTRL_APPLY = 0;
    localparam int VMET_CTRL_DELETE = 1;
    localparam int VMET_CTRL_SAVE = 2;
    localparam int VMET_CTRL_FACTORY = 3;
    localparam int VMET_CTRL_FETCH = 4;
    localparam int VMET_ST_REFUSED = 0;
    localparam int VMET_ST_BAD_OP = 1;
    localparam int VMET_ST_FOUND = 2;
    localparam int VMET_PCFG_FILTER = 16;
    localparam int VMET_DYN_PORT_LSB = 16;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [11:0] VMET_FALLBACK_VID = 12'h001;
    localparam logic [11:0] VMET_NULL_VID = 12'h000;
    localparam logic [31:0] VMET_RST_WORD = 32'h0000_0000;

    // Per-port membership code: {forbid, egress}
    typedef enum logic [1:0] {
        VMET_NON_MEMBER,
        VMET_EGRESS_MEMBER,
        VMET_FORBIDDEN
    } vmet_member_t;

endpackage
